//--- core/anp_pkg.sv
// constants for the negotiation page and master/slave register bank
package anp_pkg;

  // ==========================================================
  // register port geometry
  localparam int ANP_ADDR_W = 5;
  localparam int ANP_DATA_W = 16;

  // ==========================================================
  // register offsets
  localparam logic [4:0] ANP_REG_LPA = 5'h05; // partner ability, tail only
  localparam logic [4:0] ANP_REG_EXP = 5'h06; // negotiation_expansion
  localparam logic [4:0] ANP_REG_NPT = 5'h07; // next_page_transmit
  localparam logic [4:0] ANP_REG_NPR = 5'h08; // partner_next_page_received
  localparam logic [4:0] ANP_REG_MSC = 5'h09; // master_slave_control

  // ==========================================================
  // partner ability fields
  localparam int LPA_HD10_BIT = 5;
  localparam int LPA_SEL_MSB = 4;
  localparam int LPA_SEL_LSB = 0;

  // ==========================================================
  // expansion fields
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_LNP_BIT = 2;
  localparam int EXP_PRX_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;
  localparam logic EXP_LNP_VAL = 1'b1;

  // ==========================================================
  // code word fields, shared by transmit and received pages
  localparam int CW_NP_BIT = 15;
  localparam int CW_RSV_BIT = 14;
  localparam int CW_MP_BIT = 13;
  localparam int CW_ACK2_BIT = 12;
  localparam int CW_TOG_BIT = 11;
  localparam int CW_CODE_MSB = 10;
  localparam int CW_CODE_LSB = 0;
  localparam logic NPT_NP_RST = 1'b0;
  localparam logic NPT_MP_RST = 1'b1;
  localparam logic NPT_ACK2_RST = 1'b0;
  localparam logic [10:0] NPT_CODE_RST = 11'h001;

  // ==========================================================
  // master/slave control fields
  localparam int MSC_TM_MSB = 15;
  localparam int MSC_TM_LSB = 13;
  localparam int MSC_MAN_BIT = 12;
  localparam int MSC_CFG_BIT = 11;
  localparam logic MSC_MAN_RST = 1'b0;
  localparam logic MSC_CFG_RST = 1'b0;

  // test mode codes
  typedef enum logic [2:0] {
    ANP_TM_NORMAL = 3'h0,
    ANP_TM_WAVE = 3'h1,
    ANP_TM_JIT_MASTER = 3'h2,
    ANP_TM_JIT_SLAVE = 3'h3
  } anp_test_mode_t;

endpackage

//--- core/anp_toggle_if.sv
// carrier between the register bank and the toggle tracker
`timescale 1ns/1ns
interface anp_toggle_if;
  logic clear;
  logic base_sent;
  logic base_toggle;
  logic np_sent;
  logic tx_toggle;

  // register bank side
  modport bank (output clear, output base_sent, output base_toggle, output np_sent,
                input tx_toggle);
  // tracker side
  modport trk (input clear, input base_sent, input base_toggle, input np_sent,
               output tx_toggle);
endinterface

//--- core/anp_toggle.sv
// toggle bit tracker for outgoing next pages
`timescale 1ns/1ns
module anp_toggle import anp_pkg::*; (
  // clock and reset
  input logic ref_clk,
  input logic rst,
  // bank link
  anp_toggle_if.trk tg
);

  logic tog_ff;

  // ==========================================================
  // complement of last page sent, base page first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tog_ff <= 1'b0;
    end else if (tg.clear) begin
      tog_ff <= 1'b0;
    end else if (tg.base_sent) begin
      tog_ff <= ~tg.base_toggle; // [RULE_20]
    end else if (tg.np_sent) begin
      tog_ff <= ~tog_ff; // [RULE_10] [RULE_20]
    end
  end

  assign tg.tx_toggle = tog_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_tog_flip;
    (tg.np_sent && !tg.base_sent && !tg.clear) |=> (tg.tx_toggle != $past(tg.tx_toggle));
  endproperty
  a_tog_flip: assert property (p_tog_flip) else $error("toggle did not flip"); // [RULE_20]

  property p_tog_base;
    (tg.base_sent && !tg.clear) |=> (tg.tx_toggle == !$past(tg.base_toggle));
  endproperty
  a_tog_base: assert property (p_tog_base) else $error("toggle not base complement"); // [RULE_10]

endmodule // anp_toggle

//--- core/anp_regs.sv
// negotiation page, expansion and master/slave control register bank
//
// Behaviour
// [RULE_01] partner ability bit 5 and bits 4:0 read-only, reset to zero
// [RULE_02] expansion bit 4 latches parallel-detect fault, clears on read
// [RULE_03] expansion bit 3 latches when partner shows next-page ability
// [RULE_04] expansion bit 2 always reads one
// [RULE_05] expansion bit 1 latches on new page, clears on read
// [RULE_06] expansion bit 0 shows partner negotiation ability
// [RULE_07] transmit bit 15 writable next-page flag, resets to zero
// [RULE_08] transmit bit 14 reads zero; bit 13 selects message page, resets one
// [RULE_09] transmit bit 12 writable acknowledge-2, resets to zero
// [RULE_10] transmit bit 11 is inverse of previous toggle, read-only
// [RULE_11] transmit bits 10:0 writable code field, reset to one
// [RULE_12] received register holds partner code word, read-only
// [RULE_13] received bit 13 marks message or unformatted page
// [RULE_14] test-mode field 15:13 selects normal or transmit test modes
// [RULE_15] test modes 2 and 3 put transmit test clock on receive clock pin
// [RULE_16] leaving a test mode needs a hardware or software reset; here a write of mode 0 leaves it and software reset keeps the mode
// [RULE_17] control bit 12 selects manual master/slave assignment
// [RULE_18] master/slave bits stored at once, applied on reset, restart, wake, link loss
// [RULE_19] bit 11 forces master or slave, ignored unless manual
// [RULE_20] transmitted toggle inverts each next page, from base page complement
`timescale 1ns/1ns
module anp_regs import anp_pkg::*; (
  // clock and reset
  input logic ref_clk,
  input logic rst,
  // management register port
  input logic [ANP_ADDR_W-1:0] mgmt_addr,
  input logic [ANP_DATA_W-1:0] mgmt_wdata,
  input logic mgmt_wr,
  input logic mgmt_rd,
  output logic [ANP_DATA_W-1:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // control events from the base registers
  input logic sw_reset,
  input logic an_restart,
  input logic pd_exit,
  input logic link_down,
  // negotiation engine: received pages and events
  input logic lp_base_valid,
  input logic [ANP_DATA_W-1:0] lp_base_word,
  input logic rx_np_valid,
  input logic [ANP_DATA_W-1:0] rx_np_word,
  input logic pd_fault,
  input logic lp_np_able,
  input logic page_rx,
  input logic lp_an_able,
  // negotiation engine: transmitted pages
  input logic base_sent,
  input logic base_toggle,
  input logic np_sent,
  output logic [ANP_DATA_W-1:0] tx_np_word,
  // applied master/slave and test controls
  output logic [2:0] test_mode,
  output logic ms_manual,
  output logic ms_master,
  // receive clock pin selection
  input logic rx_clk_core,
  input logic transmit_test_clock,
  output logic rx_clk_pin
);

  // ==========================================================
  // address decode helper
  function automatic logic hit(input logic [ANP_ADDR_W-1:0] a,
                               input logic [ANP_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  logic wr_npt, wr_msc, rd_exp, apply_ms;

  // strobes for this bank's registers
  assign wr_npt = mgmt_wr && hit(mgmt_addr, ANP_REG_NPT);
  assign wr_msc = mgmt_wr && hit(mgmt_addr, ANP_REG_MSC);
  assign rd_exp = mgmt_rd && hit(mgmt_addr, ANP_REG_EXP);
  // configuration take-effect events
  assign apply_ms = sw_reset || an_restart || pd_exit || link_down; // [RULE_18]

  // ==========================================================
  // partner ability tail
  logic lpa_hd10_ff;
  logic [4:0] lpa_sel_ff;

  // captured from the partner base page, cleared by software reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lpa_hd10_ff <= 1'b0;
      lpa_sel_ff <= 5'h00;
    end else if (sw_reset) begin
      lpa_hd10_ff <= 1'b0;
      lpa_sel_ff <= 5'h00;
    end else if (lp_base_valid) begin
      lpa_hd10_ff <= lp_base_word[LPA_HD10_BIT]; // [RULE_01]
      lpa_sel_ff <= lp_base_word[LPA_SEL_MSB:LPA_SEL_LSB]; // [RULE_01]
    end
  end

  // ==========================================================
  // expansion flags
  logic exp_pdf_ff, exp_lpnp_ff, exp_prx_ff, exp_lpan_ff;

  // parallel-detect fault: set wins over read clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exp_pdf_ff <= 1'b0;
    end else if (pd_fault) begin
      exp_pdf_ff <= 1'b1; // [RULE_02]
    end else if (sw_reset || rd_exp) begin
      exp_pdf_ff <= 1'b0; // [RULE_02]
    end
  end

  // partner next-page ability, latched until software reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exp_lpnp_ff <= 1'b0;
    end else if (lp_np_able) begin
      exp_lpnp_ff <= 1'b1; // [RULE_03]
    end else if (sw_reset) begin
      exp_lpnp_ff <= 1'b0;
    end
  end

  // page received: set wins over read clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exp_prx_ff <= 1'b0;
    end else if (page_rx) begin
      exp_prx_ff <= 1'b1; // [RULE_05]
    end else if (rd_exp) begin
      exp_prx_ff <= 1'b0; // [RULE_05]
    end
  end

  // partner negotiation ability, sampled level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exp_lpan_ff <= 1'b0;
    end else begin
      exp_lpan_ff <= lp_an_able; // [RULE_06]
    end
  end

  // ==========================================================
  // transmit next page
  logic npt_np_ff, npt_mp_ff, npt_ack2_ff;
  logic [10:0] npt_code_ff;

  // software-writable fields of the outgoing page
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      npt_np_ff <= NPT_NP_RST;
      npt_mp_ff <= NPT_MP_RST;
      npt_ack2_ff <= NPT_ACK2_RST;
      npt_code_ff <= NPT_CODE_RST;
    end else if (wr_npt) begin
      npt_np_ff <= mgmt_wdata[CW_NP_BIT]; // [RULE_07]
      npt_mp_ff <= mgmt_wdata[CW_MP_BIT]; // [RULE_08]
      npt_ack2_ff <= mgmt_wdata[CW_ACK2_BIT]; // [RULE_09]
      npt_code_ff <= mgmt_wdata[CW_CODE_MSB:CW_CODE_LSB]; // [RULE_11]
    end
  end

  // toggle tracker
  anp_toggle_if tg_if ();
  assign tg_if.clear = sw_reset;
  assign tg_if.base_sent = base_sent;
  assign tg_if.base_toggle = base_toggle;
  assign tg_if.np_sent = np_sent;

  anp_toggle u_toggle (
    .ref_clk(ref_clk),
    .rst(rst),
    .tg(tg_if.trk)
  );

  // outgoing code word, reserved bit held low
  assign tx_np_word = {npt_np_ff, 1'b0, npt_mp_ff, npt_ack2_ff, tg_if.tx_toggle,
                       npt_code_ff}; // [RULE_07] [RULE_08] [RULE_10] [RULE_11]

  // ==========================================================
  // received next page
  logic [ANP_DATA_W-1:0] npr_ff;

  // partner code word, kept whole
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      npr_ff <= 16'h0000;
    end else if (sw_reset) begin
      npr_ff <= 16'h0000;
    end else if (rx_np_valid) begin
      npr_ff <= rx_np_word; // [RULE_12] [RULE_13]
    end
  end

  // ==========================================================
  // master/slave control
  logic [2:0] msc_tm_ff;
  logic msc_man_ff, msc_cfg_ff, ms_man_app_ff, ms_cfg_app_ff, rx_tst_sel_ff;

  // stored fields, visible on read at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      msc_tm_ff <= ANP_TM_NORMAL;
      msc_man_ff <= MSC_MAN_RST;
      msc_cfg_ff <= MSC_CFG_RST;
    end else if (wr_msc) begin
      msc_tm_ff <= mgmt_wdata[MSC_TM_MSB:MSC_TM_LSB]; // [RULE_14]
      msc_man_ff <= mgmt_wdata[MSC_MAN_BIT]; // [RULE_17]
      msc_cfg_ff <= mgmt_wdata[MSC_CFG_BIT]; // [RULE_19]
    end
  end

  // applied copies follow only on a take-effect event
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ms_man_app_ff <= MSC_MAN_RST;
      ms_cfg_app_ff <= MSC_CFG_RST;
    end else if (apply_ms) begin
      ms_man_app_ff <= msc_man_ff; // [RULE_18]
      ms_cfg_app_ff <= msc_cfg_ff; // [RULE_18]
    end
  end

  // receive clock source select for jitter test
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_tst_sel_ff <= 1'b0;
    end else begin
      rx_tst_sel_ff <= (msc_tm_ff == ANP_TM_JIT_MASTER) ||
                       (msc_tm_ff == ANP_TM_JIT_SLAVE); // [RULE_15]
    end
  end

  // test mode is live; a hardware reset or a write of mode 0 restores normal use
  assign test_mode = msc_tm_ff; // [RULE_14] [RULE_16]
  assign ms_manual = ms_man_app_ff; // [RULE_17]
  assign ms_master = ms_man_app_ff && ms_cfg_app_ff; // [RULE_19]
  assign rx_clk_pin = rx_tst_sel_ff ? transmit_test_clock : rx_clk_core; // [RULE_15]

  // ==========================================================
  // read data, one cycle after the strobe
  logic [ANP_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (mgmt_addr)
      ANP_REG_LPA: begin
        rd_mux[LPA_HD10_BIT] = lpa_hd10_ff; // [RULE_01]
        rd_mux[LPA_SEL_MSB:LPA_SEL_LSB] = lpa_sel_ff;
      end
      ANP_REG_EXP: begin
        rd_mux[EXP_PDF_BIT] = exp_pdf_ff;
        rd_mux[EXP_LPNP_BIT] = exp_lpnp_ff;
        rd_mux[EXP_LNP_BIT] = EXP_LNP_VAL; // [RULE_04]
        rd_mux[EXP_PRX_BIT] = exp_prx_ff;
        rd_mux[EXP_LPAN_BIT] = exp_lpan_ff;
      end
      ANP_REG_NPT: begin
        rd_mux = tx_np_word;
      end
      ANP_REG_NPR: begin
        rd_mux = npr_ff; // [RULE_12]
      end
      ANP_REG_MSC: begin
        rd_mux[MSC_TM_MSB:MSC_TM_LSB] = msc_tm_ff;
        rd_mux[MSC_MAN_BIT] = msc_man_ff;
        rd_mux[MSC_CFG_BIT] = msc_cfg_ff;
      end
      default: begin
        rd_mux = 16'h0000; // unmapped reads zero
      end
    endcase
  end

  // registered read data and valid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_exp_read;
    mgmt_rd && hit(mgmt_addr, ANP_REG_EXP);
  endsequence

  sequence s_quiet_exp;
    !pd_fault && !page_rx;
  endsequence

  property p_lpa_clear;
    sw_reset |=> (lpa_hd10_ff == 1'b0) && (lpa_sel_ff == 5'h00);
  endproperty
  a_lpa_clear: assert property (p_lpa_clear) else $error("partner ability not cleared"); // [RULE_01]
  property p_pdf_set_read;
    pd_fault ##1 (s_exp_read and s_quiet_exp) |=> mgmt_rdata[EXP_PDF_BIT] ##0
      !exp_pdf_ff;
  endproperty
  a_pdf_set_read: assert property (p_pdf_set_read) else $error("fault flag read-clear"); // [RULE_02]
  property p_lpnp_hold;
    (exp_lpnp_ff && !sw_reset) |=> exp_lpnp_ff;
  endproperty
  a_lpnp_hold: assert property (p_lpnp_hold) else $error("next-page able dropped"); // [RULE_03]
  property p_lnp_one;
    s_exp_read |=> mgmt_rvalid && mgmt_rdata[EXP_LNP_BIT];
  endproperty
  a_lnp_one: assert property (p_lnp_one) else $error("local next-page bit not one"); // [RULE_04]
  property p_prx_keep;
    (page_rx && !rd_exp) |=> exp_prx_ff ##1 (exp_prx_ff || $past(rd_exp));
  endproperty
  a_prx_keep: assert property (p_prx_keep) else $error("page received not latched"); // [RULE_05]
  property p_lpan_follow;
    lp_an_able ##1 lp_an_able |-> exp_lpan_ff;
  endproperty
  a_lpan_follow: assert property (p_lpan_follow) else $error("negotiation able wrong"); // [RULE_06]
  property p_npt_write;
    wr_npt |=> (tx_np_word[CW_NP_BIT] == $past(mgmt_wdata[CW_NP_BIT])) &&
      (tx_np_word[CW_CODE_MSB:CW_CODE_LSB] == $past(mgmt_wdata[CW_CODE_MSB:CW_CODE_LSB]));
  endproperty
  a_npt_write: assert property (p_npt_write) else $error("transmit page not written"); // [RULE_07]
  property p_npt_rsv;
    !tx_np_word[CW_RSV_BIT];
  endproperty
  a_npt_rsv: assert property (p_npt_rsv) else $error("transmit reserved bit set"); // [RULE_08]
  property p_npr_hold;
    rx_np_valid && !sw_reset |=> (npr_ff == $past(rx_np_word));
  endproperty
  a_npr_hold: assert property (p_npr_hold) else $error("received page not held"); // [RULE_12]
  property p_tm_write;
    wr_msc |=> test_mode == $past(mgmt_wdata[MSC_TM_MSB:MSC_TM_LSB]);
  endproperty
  a_tm_write: assert property (p_tm_write) else $error("test mode not taken"); // [RULE_14]
  property p_tclk_sel;
    (test_mode == ANP_TM_JIT_MASTER) ##1 (test_mode == ANP_TM_JIT_MASTER) |->
      (rx_clk_pin == transmit_test_clock);
  endproperty
  a_tclk_sel: assert property (p_tclk_sel) else $error("test clock not on pin"); // [RULE_15]
  property p_ms_defer;
    !apply_ms |=> $stable(ms_manual) && $stable(ms_master);
  endproperty
  a_ms_defer: assert property (p_ms_defer) else $error("master/slave applied early"); // [RULE_18]
  property p_ms_apply;
    apply_ms |=> (ms_manual == $past(msc_man_ff));
  endproperty
  a_ms_apply: assert property (p_ms_apply) else $error("master/slave not applied"); // [RULE_17]
  property p_ms_ignore;
    !ms_manual |-> !ms_master;
  endproperty
  a_ms_ignore: assert property (p_ms_ignore) else $error("force master when automatic"); // [RULE_19]

endmodule // anp_regs

//--- tb/anp_partner_model.sv
// link partner model: hands received pages and negotiation ability to the bank
`timescale 1ns/1ns
module anp_partner_model (
  // clock
  input wire logic ref_clk,
  // received pages
  output logic lp_base_valid,
  output logic [15:0] lp_base_word,
  output logic rx_np_valid,
  output logic [15:0] rx_np_word,
  // partner ability level
  output logic lp_an_able
);
  // idle lines at time zero
  initial begin
    lp_base_valid = 1'b0;
    lp_base_word = 16'h0000;
    rx_np_valid = 1'b0;
    rx_np_word = 16'h0000;
    lp_an_able = 1'b0;
  end

  // one base page; word line shows junk once the page is gone
  task automatic send_base(input logic [15:0] w);
    @(negedge ref_clk);
    lp_base_valid = 1'b1;
    lp_base_word = w;
    @(negedge ref_clk);
    lp_base_valid = 1'b0;
    lp_base_word = ~w;
  endtask

  // one next page code word, sent whole
  task automatic send_np(input logic [15:0] w);
    @(negedge ref_clk);
    rx_np_valid = 1'b1;
    rx_np_word = w;
    @(negedge ref_clk);
    rx_np_valid = 1'b0;
    rx_np_word = ~w;
  endtask

  // partner shows or withdraws negotiation ability
  task automatic set_able(input logic v);
    @(negedge ref_clk);
    lp_an_able = v;
  endtask
endmodule // anp_partner_model

//--- tb/test_autoneg_next_page_msl_regs.sv
// self-checking bench for the negotiation page and master/slave register bank
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_autoneg_next_page_msl_regs import anp_pkg::*;;
  logic ref_clk, rst, mgmt_wr, mgmt_rd, mgmt_rvalid, base_toggle, tog;
  logic rx_clk_core, transmit_test_clock, rx_clk_pin, ms_manual, ms_master;
  logic lp_base_valid, rx_np_valid, lp_an_able;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, tx_np_word, lp_base_word, rx_np_word, w;
  logic [2:0] test_mode;
  logic [1:0] cfg, app;
  logic [8:0] ev; // event pulses, one bit each
  int err_count, n_compared;

  // ==========================================================
  // instances
  anp_regs anp_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .sw_reset(ev[0]), .an_restart(ev[1]), .pd_exit(ev[2]),
    .link_down(ev[3]), .lp_base_valid(lp_base_valid), .lp_base_word(lp_base_word),
    .rx_np_valid(rx_np_valid), .rx_np_word(rx_np_word), .pd_fault(ev[4]),
    .lp_np_able(ev[5]), .page_rx(ev[6]), .lp_an_able(lp_an_able), .base_sent(ev[7]),
    .base_toggle(base_toggle), .np_sent(ev[8]), .tx_np_word(tx_np_word),
    .test_mode(test_mode), .ms_manual(ms_manual), .ms_master(ms_master),
    .rx_clk_core(rx_clk_core), .transmit_test_clock(transmit_test_clock),
    .rx_clk_pin(rx_clk_pin)
  );
  anp_partner_model anp_partner_model_inst (
    .ref_clk(ref_clk), .lp_base_valid(lp_base_valid), .lp_base_word(lp_base_word),
    .rx_np_valid(rx_np_valid), .rx_np_word(rx_np_word), .lp_an_able(lp_an_able)
  );

  // ==========================================================
  // helpers
  // expected outgoing page: bit 14 zero, toggle owned by the device
  function automatic logic [15:0] exp_npt(input logic [15:0] d, input logic t);
    return {d[15], 1'b0, d[13:12], t, d[10:0]};
  endfunction

  // single-cycle write strobe
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(negedge ref_clk);
    mgmt_wr = 1'b0;
  endtask

  // single-cycle read, answer checked one cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    @(negedge ref_clk);
    mgmt_rd = 1'b0;
    `CHK(mgmt_rvalid, 1'b1)
    `CHK(mgmt_rdata, e)
  endtask

  // one-cycle event pulse
  task automatic pulse(input int i);
    @(negedge ref_clk);
    ev[i] = 1'b1;
    @(negedge ref_clk);
    ev = '0;
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    ev = '0;
    base_toggle = 1'b0;
    rx_clk_core = 1'b0;
    transmit_test_clock = 1'b1;
    app = 2'b00;
    err_count = 0;
    n_compared = 0;
    void'($urandom(14));
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    // reset values, unmapped read gives zero
    rd_chk(ANP_REG_LPA, 16'h0000);
    rd_chk(ANP_REG_EXP, 16'h0004);
    rd_chk(ANP_REG_NPT, 16'h2001);
    rd_chk(ANP_REG_NPR, 16'h0000);
    rd_chk(ANP_REG_MSC, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    // partner base pages, only the ability tail is kept, writes ignored
    repeat (4) begin
      w = 16'($urandom);
      anp_partner_model_inst.send_base(w);
      wr_reg(ANP_REG_LPA, ~w);
      rd_chk(ANP_REG_LPA, {10'h000, w[5:0]});
    end
    // latched flags, then clear-on-read of bits 4 and 1 only
    anp_partner_model_inst.set_able(1'b1);
    pulse(4);
    pulse(5);
    pulse(6);
    rd_chk(ANP_REG_EXP, 16'h001f);
    rd_chk(ANP_REG_EXP, 16'h000d);
    // set and read-clear in one cycle: set wins, then a back-to-back read
    @(negedge ref_clk);
    ev[4] = 1'b1;
    ev[6] = 1'b1;
    mgmt_addr = ANP_REG_EXP;
    mgmt_rd = 1'b1;
    @(negedge ref_clk);
    ev = '0;
    `CHK(mgmt_rdata, 16'h000d)
    @(negedge ref_clk);
    mgmt_rd = 1'b0;
    `CHK(mgmt_rdata, 16'h001f)
    wr_reg(ANP_REG_EXP, 16'hffff);
    rd_chk(ANP_REG_EXP, 16'h000d);
    // outgoing page: writable fields, fixed bit 14, device-owned toggle
    tog = 1'b0;
    repeat (4) begin
      w = 16'($urandom);
      wr_reg(ANP_REG_NPT, w);
      `CHK(tx_np_word, exp_npt(w, tog))
      rd_chk(ANP_REG_NPT, exp_npt(w, tog));
    end
    base_toggle = w[0];
    pulse(7);
    tog = ~w[0];
    `CHK(tx_np_word[11], tog)
    repeat (3) begin
      pulse(8);
      tog = ~tog;
      `CHK(tx_np_word[11], tog)
    end
    // partner next pages kept whole, writes ignored
    repeat (4) begin
      w = 16'($urandom);
      anp_partner_model_inst.send_np(w);
      wr_reg(ANP_REG_NPR, ~w);
      rd_chk(ANP_REG_NPR, w);
    end
    // software reset clears received state
    pulse(0);
    rd_chk(ANP_REG_LPA, 16'h0000);
    rd_chk(ANP_REG_NPR, 16'h0000);
    rd_chk(ANP_REG_EXP, 16'h0005);
    // every test mode, clock pin follows modes 2 and 3
    for (int m = 0; m < 4; m++) begin
      wr_reg(ANP_REG_MSC, {m[2:0], 13'h0000});
      `CHK(test_mode, m[2:0])
      @(negedge ref_clk);
      `CHK(rx_clk_pin, (m >= 2))
      rd_chk(ANP_REG_MSC, {m[2:0], 13'h0000});
    end
    wr_reg(ANP_REG_MSC, 16'h0000);
    pulse(0);
    @(negedge ref_clk);
    `CHK(rx_clk_pin, 1'b0)
    // master/slave store at once, apply on each of the four events
    for (int i = 0; i < 4; i++) begin
      cfg = 2'($urandom_range(3, 0));
      if (i == 0) cfg = 2'b11;
      if (i == 1) cfg = 2'b01;
      wr_reg(ANP_REG_MSC, {3'h0, cfg, 11'h000});
      rd_chk(ANP_REG_MSC, {3'h0, cfg, 11'h000});
      `CHK({ms_manual, ms_master}, app)
      pulse(i);
      app = {cfg[1], cfg[1] & cfg[0]};
      `CHK({ms_manual, ms_master}, app)
    end
    tally_and_finish();
  end
endmodule // test_autoneg_next_page_msl_regs
